// ---- rtl/phcb_bank.sv ----
// configuration bank with lock, holdover, dac and loss-of-signal logic
// assumes loop status arrives as synchronous ticks and window flags
`timescale 1ns/1ps
module phcb_bank (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // serial programming pins
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_serial_latch_enable,
  output logic o_sdo,
  // loop one status
  input wire logic i_loop_one_pd_tick,
  input wire logic i_loop_one_in_window,
  input wire logic [phcb_pkg::DAC_W-1:0] i_tune_code,
  // loop two status
  input wire logic i_loop_two_pd_tick,
  input wire logic i_loop_two_in_window,
  // reference activity pulses
  input wire logic [2:0] i_ref_activity,
  // control and status outputs
  output phcb_pkg::phcb_cfg_s o_cfg,
  output logic [phcb_pkg::DAC_W-1:0] o_dac_code,
  output logic o_loop_one_locked,
  output logic o_loop_two_locked,
  output logic o_holdover,
  output logic o_rail_trip,
  output logic [2:0] o_input_signal_loss
);
  import phcb_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // declarations

  typedef enum logic {HO_TRACK, HO_HOLD} phcb_ho_e;

  // whole reset word of the manual dac register; the live dac starts here
  localparam logic [31:0] MANUAL_DAC_VALUE_RST = reg_reset(A_MANUAL_DAC_VALUE);

  logic [31:0] regs_q [REG_NUM]; // register file
  logic [31:0] frame; // word from the serial port
  logic frame_valid; // one-cycle frame strobe
  logic [4:0] wr_addr; // frame address bits
  logic wr_en; // accepted write
  logic [31:0] rd_word; // readback candidate
  logic [4:0] rb_addr; // selected readback register
  logic [DAC_W-1:0] dac_q; // live dac value
  logic [DAC_W-1:0] dac_div_q; // dac update prescaler
  logic dac_tick; // dac update strobe
  logic [DAC_W-1:0] hi_lim; // high trip code
  logic [DAC_W-1:0] lo_lim; // low trip code
  logic rail_trip_q; // dac at a rail
  logic l1_valid; // loop one window honoured
  logic l1_lock; // loop one qualified
  logic l1_lock_q; // previous qualified level
  logic l2_lock; // loop two qualified
  logic ho_exit; // holdover exit qualified
  phcb_ho_e ho_q; // holdover state
  logic [LOS_W-1:0] los_cnt_q [3]; // per-input idle counters
  logic [2:0] los_q; // per-input loss flags

  ////////////////////////////////////////////////////////////////////
  // serial port

  phcb_serial_port u_port (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_sclk(i_sclk),
    .i_sdata(i_sdata),
    .i_latch(i_serial_latch_enable),
    .o_sdo(o_sdo),
    .i_readback_level(regs_q[A_READBACK][F_RB_LEVEL]),
    .i_read_word(rd_word),
    .o_word_valid(frame_valid),
    .o_word(frame)
  );

  // low five bits carry the address
  assign wr_addr = frame[ADDR_W-1:0];

  // register 31 itself always stays writable so the lock can be lifted
  assign wr_en = frame_valid &&
                 (wr_addr == A_READBACK ||
                  !regs_q[A_READBACK][F_WLOCK]);

  ////////////////////////////////////////////////////////////////////
  // register file

  // one writable word per address, reserved bits forced to zero
  for (genvar g = 0; g < REG_NUM; g++) begin : g_reg
    always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
        regs_q[g] <= reg_reset(5'(g));
      end else if (wr_en && wr_addr == 5'(g)) begin
        regs_q[g] <= frame & reg_mask(5'(g));
      end
    end
  end

  // readback source; the dac field shows the live value
  assign rb_addr = regs_q[A_READBACK][F_RB_ADDR +: ADDR_W];
  always_comb begin
    rd_word = regs_q[rb_addr];
    if (rb_addr == A_MANUAL_DAC_VALUE) begin
      rd_word[F_MANUAL_DAC_VALUE +: DAC_W] = dac_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // static controls, registered so outputs come from flops

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_cfg <= '0;
    end else begin
      o_cfg.buf_type <= regs_q[A_BUF_TRIP][F_BUF_TYPE +: 3];
      // code n divides by two to the n
      for (int i = 0; i < 3; i++) begin
        o_cfg.predivide_ratio[i] <= PREDIV_ONE <<
          regs_q[A_L1_PUMP][F_PREDIV + 2*i +: 2];
      end
      o_cfg.loop_one_reference_divider <=
        regs_q[A_L1_PUMP][F_L1_R +: 14];
      o_cfg.loop_one_feedback_divider <=
        regs_q[A_DIV_RN][F_L1_N +: 14];
      o_cfg.loop_two_reference_divider <=
        regs_q[A_DIV_RN][F_L2_R +: 12];
      o_cfg.loop_two_feedback_divider <=
        regs_q[A_L2_FB][F_L2_N +: 18];
      // copy is only passed on; software must keep it equal
      o_cfg.loop_two_feedback_calibration_copy <=
        regs_q[A_CAL][F_CAL +: 18];
      o_cfg.loop_two_prescaler <=
        regs_q[A_L2_FB][F_L2_P +: 3];
      o_cfg.reference_doubler_enable <=
        regs_q[A_L2_PUMP][F_DBL];
      o_cfg.fast_comparison_enable <=
        regs_q[A_CAL][F_FAST];
      o_cfg.loop_one_lock_window <=
        regs_q[A_LOOP_FILT][F_L1_WIN +: 2];
      o_cfg.loop_one_pump_tristate <=
        regs_q[A_L1_PUMP][F_TRI];
      o_cfg.loop_two_pump_tristate <=
        regs_q[A_L2_PUMP][F_TRI];
      o_cfg.loop_one_pump_setting <= regs_q[A_L1_PUMP][F_GAIN +: 3];
      o_cfg.loop_two_pump_setting <= regs_q[A_L2_PUMP][F_GAIN +: 3];
      o_cfg.crystal_level <= regs_q[A_XTAL][F_XTAL +: 2];
      o_cfg.osc_range <= regs_q[A_CAL][F_OSC +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // dac update clock and value

  // divisor of zero behaves as one; avoids a stalled dac
  assign dac_tick = i_loop_one_pd_tick &&
    (dac_div_q + 1'b1 >= regs_q[A_DAC_CLK][F_DAC_DIV +: DAC_W]);

  // prescaler counts comparison cycles
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      dac_div_q <= '0;
    end else if (dac_tick) begin
      dac_div_q <= '0;
    end else if (i_loop_one_pd_tick) begin
      dac_div_q <= dac_div_q + 1'b1;
    end
  end

  // manual value wins; tracking freezes while in holdover
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      dac_q <= MANUAL_DAC_VALUE_RST[F_MANUAL_DAC_VALUE +: DAC_W];
    end else if (dac_tick) begin
      if (regs_q[A_MANUAL_DAC_VALUE][F_MAN_EN]) begin
        dac_q <= regs_q[A_MANUAL_DAC_VALUE][F_MANUAL_DAC_VALUE +: DAC_W];
      end else if (ho_q == HO_TRACK) begin
        dac_q <= i_tune_code;
      end
    end
  end

  // live code out
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_dac_code <= '0;
    end else begin
      o_dac_code <= dac_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // rail detection

  // high level measured down from the top, low level up from zero
  assign hi_lim = DAC_MAX - TRIP_BASE -
    DAC_W'(regs_q[A_BUF_TRIP][F_HIGH_TRIP +: 6]);
  assign lo_lim = TRIP_BASE +
    DAC_W'(regs_q[A_BUF_TRIP][F_LOW_TRIP +: 6]);

  // trip flag
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rail_trip_q <= 1'b0;
    end else begin
      rail_trip_q <= regs_q[A_BUF_TRIP][F_RAIL_EN] &&
                     (dac_q >= hi_lim || dac_q <= lo_lim);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // lock qualification

  // a rail trip counts as loop one out of window
  assign l1_valid = i_loop_one_in_window && !rail_trip_q;

  phcb_lock_count #(.W(CNT_W)) u_l1_lock (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_tick(i_loop_one_pd_tick),
    .i_valid(l1_valid),
    .i_target(regs_q[A_DAC_CLK][F_L1_CNT +: CNT_W]),
    .o_reached(l1_lock)
  );

  phcb_lock_count #(.W(CNT_W)) u_l2_lock (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_tick(i_loop_two_pd_tick),
    .i_valid(i_loop_two_in_window),
    .i_target(regs_q[A_L2_PUMP][F_L2_CNT +: CNT_W]),
    .o_reached(l2_lock)
  );

  // exit count only runs while holding
  phcb_lock_count #(.W(CNT_W)) u_ho_exit (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_tick(i_loop_one_pd_tick),
    .i_valid(l1_valid && ho_q == HO_HOLD),
    .i_target(regs_q[A_MANUAL_DAC_VALUE][F_HO_CNT +: CNT_W]),
    .o_reached(ho_exit)
  );

  // lock outputs
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      l1_lock_q <= 1'b0;
      o_loop_one_locked <= 1'b0;
      o_loop_two_locked <= 1'b0;
    end else begin
      l1_lock_q <= l1_lock;
      o_loop_one_locked <= l1_lock;
      o_loop_two_locked <= l2_lock;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // holdover

  // enter on loss of loop one lock or force; leave on exit count
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ho_q <= HO_TRACK;
    end else begin
      case (ho_q)
        HO_TRACK: begin
          if (regs_q[A_MANUAL_DAC_VALUE][F_FORCE_HO] || (l1_lock_q && !l1_lock)) begin
            ho_q <= HO_HOLD;
          end
        end
        HO_HOLD: begin
          if (ho_exit && !regs_q[A_MANUAL_DAC_VALUE][F_FORCE_HO]) begin
            ho_q <= HO_TRACK;
          end
        end
        default: begin
          ho_q <= HO_TRACK;
        end
      endcase
    end
  end

  // state flags out
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_holdover <= 1'b0;
      o_rail_trip <= 1'b0;
    end else begin
      o_holdover <= (ho_q == HO_HOLD);
      o_rail_trip <= rail_trip_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // loss of signal

  // idle counter per input, cleared only by that input's own activity pulse
  for (genvar r = 0; r < 3; r++) begin : g_los
    always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
        los_cnt_q[r] <= '0;
        los_q[r] <= 1'b0;
      end else begin
        if (i_ref_activity[r]) begin
          los_cnt_q[r] <= '0;
        end else if (los_cnt_q[r] != LOS_W'(LOS_CYCLES)) begin
          los_cnt_q[r] <= los_cnt_q[r] + 1'b1;
        end
        los_q[r] <= regs_q[A_BUF_TRIP][F_LOS_EN] &&
                    los_cnt_q[r] == LOS_W'(LOS_CYCLES);
      end
    end
  end

  // loss flags out
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_input_signal_loss <= '0;
    end else begin
      o_input_signal_loss <= los_q;
    end
  end

endmodule // phcb_bank

// ---- inc/phcb_pkg.sv ----
// constants, field positions and carrier types of the config bank
// assumes a single 25 MHz system clock; nothing else is shared
package phcb_pkg;

  // word and address layout of a serial frame
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;
  localparam int REG_NUM = 32;
  localparam int CNT_W = 14;
  localparam int DAC_W = 10;

  // register addresses
  localparam logic [4:0] A_BUF_TRIP = 5'h0e;
  localparam logic [4:0] A_MANUAL_DAC_VALUE = 5'h0f;
  localparam logic [4:0] A_XTAL = 5'h10;
  localparam logic [4:0] A_LOOP_FILT = 5'h18;
  localparam logic [4:0] A_DAC_CLK = 5'h19;
  localparam logic [4:0] A_L2_PUMP = 5'h1a;
  localparam logic [4:0] A_L1_PUMP = 5'h1b;
  localparam logic [4:0] A_DIV_RN = 5'h1c;
  localparam logic [4:0] A_CAL = 5'h1d;
  localparam logic [4:0] A_L2_FB = 5'h1e;
  localparam logic [4:0] A_READBACK = 5'h1f;

  // field lsb positions
  localparam int F_LOS_EN = 28;
  localparam int F_BUF_TYPE = 20;
  localparam int F_HIGH_TRIP = 14;
  localparam int F_LOW_TRIP = 6;
  localparam int F_RAIL_EN = 5;
  localparam int F_MANUAL_DAC_VALUE = 22;
  localparam int F_MAN_EN = 20;
  localparam int F_HO_CNT = 6;
  localparam int F_FORCE_HO = 5;
  localparam int F_XTAL = 30;
  localparam int F_L1_WIN = 6;
  localparam int F_DAC_DIV = 22;
  localparam int F_L1_CNT = 6;
  localparam int F_DBL = 29;
  localparam int F_POL = 28;
  localparam int F_GAIN = 26;
  localparam int F_L2_CNT = 6;
  localparam int F_TRI = 5;
  localparam int F_PREDIV = 20;
  localparam int F_L1_R = 6;
  localparam int F_L2_R = 20;
  localparam int F_L1_N = 6;
  localparam int F_OSC = 24;
  localparam int F_FAST = 23;
  localparam int F_CAL = 5;
  localparam int F_L2_P = 24;
  localparam int F_L2_N = 5;
  localparam int F_RB_LEVEL = 21;
  localparam int F_RB_ADDR = 16;
  localparam int F_WLOCK = 5;

  // timing: loss-of-signal timeout
  localparam int CLK_PERIOD_NS = 40;
  localparam int LOS_TIME_NS = 1200;
  localparam int LOS_CYCLES = LOS_TIME_NS / CLK_PERIOD_NS;
  localparam int LOS_W = 6;

  // dac trip levels: base offset in codes, plus field value
  localparam logic [9:0] TRIP_BASE = 10'h010;
  localparam logic [9:0] DAC_MAX = 10'h3ff;
  localparam logic [3:0] PREDIV_ONE = 4'h1;

  // reset value per register
  function automatic logic [31:0] reg_reset(input logic [4:0] a);
    case (a)
      A_BUF_TRIP: reg_reset = 32'h12000000;
      A_MANUAL_DAC_VALUE: reg_reset = 32'h80008000;
      A_LOOP_FILT: reg_reset = 32'h000000c0;
      A_DAC_CLK: reg_reset = 32'h01010000;
      A_L2_PUMP: reg_reset = 32'h0c080000;
      A_L1_PUMP: reg_reset = 32'h10001800;
      A_DIV_RN: reg_reset = 32'h00403000;
      A_CAL: reg_reset = 32'h07800600;
      A_L2_FB: reg_reset = 32'h02000600;
      A_READBACK: reg_reset = 32'h001f0000;
      default: reg_reset = 32'h00000000;
    endcase
  endfunction

  // writable bits per register; the rest are reserved zeros
  function automatic logic [31:0] reg_mask(input logic [4:0] a);
    case (a)
      A_BUF_TRIP: reg_mask = 32'hd77fcfe0;
      A_MANUAL_DAC_VALUE: reg_mask = 32'hffdfffe0;
      A_XTAL: reg_mask = 32'hc0000000;
      A_LOOP_FILT: reg_mask = 32'hff7777c0;
      A_DAC_CLK: reg_mask = 32'hffcfffc0;
      A_L2_PUMP: reg_mask = 32'hfc0fffe0;
      A_L1_PUMP: reg_mask = 32'h1fffffe0;
      A_DIV_RN: reg_mask = 32'hffffffc0;
      A_CAL: reg_mask = 32'h07ffffe0;
      A_L2_FB: reg_mask = 32'h077fffe0;
      A_READBACK: reg_mask = 32'h003f0020;
      default: reg_mask = 32'h00000000;
    endcase
  endfunction

  // static controls fed to the loops
  typedef struct packed {
    logic [2:0] buf_type;
    logic [2:0][3:0] predivide_ratio;
    logic [13:0] loop_one_reference_divider;
    logic [13:0] loop_one_feedback_divider;
    logic [11:0] loop_two_reference_divider;
    logic [17:0] loop_two_feedback_divider;
    logic [17:0] loop_two_feedback_calibration_copy;
    logic [2:0] loop_two_prescaler;
    logic reference_doubler_enable;
    logic fast_comparison_enable;
    logic [1:0] loop_one_lock_window;
    logic loop_one_pump_tristate;
    logic loop_two_pump_tristate;
    logic [2:0] loop_one_pump_setting;
    logic [2:0] loop_two_pump_setting;
    logic [1:0] crystal_level;
    logic [2:0] osc_range;
  } phcb_cfg_s;

endpackage

// ---- rtl/phcb_lock_count.sv ----
// consecutive-valid counter used for lock and holdover qualification
// assumes i_tick is a one-cycle pulse per phase-detector cycle
`timescale 1ns/1ps
module phcb_lock_count #(
  parameter int W = 14
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // qualifier inputs
  input wire logic i_tick,
  input wire logic i_valid,
  input wire logic [W-1:0] i_target,
  // reached flag
  output logic o_reached
);
  logic [W-1:0] cnt_q; // saturating run length

  // any invalid cycle restarts the run
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_q <= '0;
    end else if (!i_valid) begin
      cnt_q <= '0;
    end else if (i_tick && cnt_q != '1) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // flag follows the run one cycle later
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_reached <= 1'b0;
    end else begin
      o_reached <= i_valid && (cnt_q >= i_target);
    end
  end
endmodule // phcb_lock_count

// ---- rtl/phcb_serial_port.sv ----
// three-wire serial port: shifts frames in, readback word out
// assumes i_sclk, i_sdata and i_latch are synchronous to i_clk
`timescale 1ns/1ps
module phcb_serial_port (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // serial pins
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_latch,
  output logic o_sdo,
  // register side
  input wire logic i_readback_level,
  input wire logic [31:0] i_read_word,
  output logic o_word_valid,
  output logic [31:0] o_word
);
  logic sclk_q; // previous clock pin level
  logic latch_q; // previous latch pin level
  logic [31:0] shift_q; // incoming frame
  logic [31:0] rb_q; // outgoing readback word

  // edge history of the pins
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sclk_q <= 1'b0;
      latch_q <= 1'b1; // pin idles high; avoids a false commit
    end else begin
      sclk_q <= i_sclk;
      latch_q <= i_latch;
    end
  end

  // msb first, sampled on the rising clock edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      shift_q <= '0;
    end else if (i_sclk && !sclk_q) begin
      shift_q <= {shift_q[30:0], i_sdata};
    end
  end

  // frame taken on the rising latch edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_word_valid <= 1'b0;
      o_word <= '0;
    end else begin
      o_word_valid <= i_latch && !latch_q;
      if (i_latch && !latch_q) begin
        o_word <= shift_q;
      end
    end
  end

  // load when latch enters the readback level, shift on falling sclk
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rb_q <= '0;
    end else if (i_latch == i_readback_level && latch_q != i_latch) begin
      rb_q <= i_read_word;
    end else if (i_latch == i_readback_level && !i_sclk && sclk_q) begin
      rb_q <= {rb_q[30:0], 1'b0};
    end
  end

  // data out pin
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_sdo <= 1'b0;
    end else begin
      o_sdo <= rb_q[31];
    end
  end
endmodule // phcb_serial_port

// ---- test/phcb_bank_chk.sv ----
// checker for the config bank status and control outputs
// assumes it is bound into phcb_bank; one clock domain
`timescale 1ns/1ps
module phcb_bank_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // loop and reference stimulus
  input wire logic i_loop_one_in_window,
  input wire logic i_loop_two_in_window,
  input wire logic [2:0] i_ref_activity,
  // watched outputs
  input wire phcb_pkg::phcb_cfg_s o_cfg,
  input wire logic o_loop_one_locked,
  input wire logic o_loop_two_locked,
  input wire logic o_holdover,
  input wire logic o_rail_trip,
  input wire logic [2:0] o_input_signal_loss
);
  import phcb_pkg::*;
  logic [1:0] up_q; // edges since release, saturating
  logic [5:0] quiet_q; // idle cycles on reference zero
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  //////////////////////////////
  // cfg only settles a few edges after release
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  // saturating, so long gaps stay visible
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || i_ref_activity[0]) quiet_q <= 6'h00;
    else if (quiet_q != 6'h3f) quiet_q <= quiet_q + 6'h01;
  end
  //////////////////////////////
  property p_l1r;
    $rose(o_loop_one_locked) |-> $past(i_loop_one_in_window, 3);
  endproperty
  a_l1r: assert property (p_l1r) else $error("lock one early");
  property p_l1d;
    !i_loop_one_in_window |-> ##[1:3] !o_loop_one_locked;
  endproperty
  a_l1d: assert property (p_l1d) else $error("lock one stuck");
  property p_l2r;
    $rose(o_loop_two_locked) |-> $past(i_loop_two_in_window, 3);
  endproperty
  a_l2r: assert property (p_l2r) else $error("lock two early");
  property p_l2d;
    !i_loop_two_in_window |-> ##[1:3] !o_loop_two_locked;
  endproperty
  a_l2d: assert property (p_l2d) else $error("lock two stuck");
  property p_ho;
    $fell(o_holdover) |-> $past(i_loop_one_in_window, 3);
  endproperty
  a_ho: assert property (p_ho) else $error("holdover left early");
  property p_rail;
    $rose(o_rail_trip) |-> ##[0:3] !o_loop_one_locked;
  endproperty
  a_rail: assert property (p_rail) else $error("rail kept lock");
  property p_pre;
    up_q == 2'h3 |-> $onehot(o_cfg.predivide_ratio[0]) &&
      $onehot(o_cfg.predivide_ratio[1]) && $onehot(o_cfg.predivide_ratio[2]);
  endproperty
  a_pre: assert property (p_pre) else $error("bad predivide");
  property p_los;
    $rose(o_input_signal_loss[0]) |-> int'(quiet_q) >= LOS_CYCLES;
  endproperty
  a_los: assert property (p_los) else $error("loss too soon");
  // main scenarios reached
  c_lock: cover property ($rose(o_loop_one_locked));
  c_exit: cover property ($fell(o_holdover));
  c_loss: cover property ($rose(o_input_signal_loss[0]));
endmodule // phcb_bank_chk

bind phcb_bank phcb_bank_chk u_chk (
  .i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_loop_one_in_window(i_loop_one_in_window),
  .i_loop_two_in_window(i_loop_two_in_window),
  .i_ref_activity(i_ref_activity), .o_cfg(o_cfg),
  .o_loop_one_locked(o_loop_one_locked),
  .o_loop_two_locked(o_loop_two_locked),
  .o_holdover(o_holdover), .o_rail_trip(o_rail_trip),
  .o_input_signal_loss(o_input_signal_loss)
);

// ---- test/phcb_host_model.sv ----
// host model on the three-wire programming pins of the config bank
// assumes pins are sampled on rising i_clk; changes land 1 ns after
`timescale 1ns/1ps
module phcb_host_model (
  // clock
  input wire logic i_clk,
  // serial pins
  output logic o_sclk,
  output logic o_sdata,
  output logic o_latch,
  input wire logic i_sdo
);
  logic lv = 1'b0; // readback latch level the next rd selects
  //////////////////////////////
  // idle: latch high, serial clock low
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_latch = 1'b1;
  end
  // keep present pin levels for n edges
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // one frame msb first; latch rise commits it
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] f;
    f = {d[31:5], a};
    o_latch = 1'b0;
    hold(2);
    for (int i = 31; i >= 0; i--) begin
      o_sdata = f[i];
      o_sclk = 1'b0;
      hold(2);
      o_sclk = 1'b1;
      hold(2);
    end
    o_sclk = 1'b0;
    o_sdata = ~o_sdata; // no stale bit left on the line
    o_latch = 1'b1;
    hold(4);
  endtask
  // select, latch to level lv, shift word out; latch stays there, since
  // a rise there would commit the bits shifted during readback
  task automatic rd(input logic [4:0] a, input logic lk,
      output logic [31:0] q);
    wr(5'h1f, {10'h0, lv, a, 10'h0, lk, 5'h0});
    o_latch = 1'b0;
    hold(3);
    // a high level loads on the rise, which recommits the same select
    if (lv) begin
      o_latch = 1'b1;
      hold(3);
    end
    for (int i = 31; i >= 0; i--) begin
      q[i] = i_sdo;
      o_sclk = 1'b1;
      hold(2);
      o_sclk = 1'b0;
      hold(3);
    end
  endtask
endmodule // phcb_host_model

// ---- test/pll_holdover_config_bank_bench.sv ----
// bench for the config bank: host model on the pins, status stimulus
// assumes the host model owns all serial pins of the bank
`timescale 1ns/1ps
module pll_holdover_config_bank_bench;
  import phcb_pkg::*;
  // clock, reset and pins
  logic i_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sclk, sdata, latch, sdo, l1, l2, ho, rail;
  logic t1 = 1'b0, w1 = 1'b0, w2 = 1'b0, tk_en = 1'b0;
  logic [2:0] act = 3'h0, act_en = 3'h0, input_signal_loss;
  logic [9:0] tune = 10'h200, dac;
  phcb_cfg_s cfg;
  // checking state
  logic [31:0] exp_q[$], res, q, r;
  logic [31:0] rnd = 32'he87b;
  string nm;
  event res_ev;
  int err_count = 0, samples_checked = 0, cyc_n = 0;
  //////////////////////////////
  phcb_bank DUT (
    .i_clk(i_clk), .i_rst_b(rst_b), .i_sclk(sclk), .i_sdata(sdata),
    .i_serial_latch_enable(latch), .o_sdo(sdo),
    .i_loop_one_pd_tick(t1), .i_loop_one_in_window(w1),
    .i_tune_code(tune), .i_loop_two_pd_tick(t1),
    .i_loop_two_in_window(w2), .i_ref_activity(act), .o_cfg(cfg),
    .o_dac_code(dac), .o_loop_one_locked(l1), .o_loop_two_locked(l2),
    .o_holdover(ho), .o_rail_trip(rail), .o_input_signal_loss(input_signal_loss)
  );
  phcb_host_model host (
    .i_clk(i_clk), .o_sclk(sclk), .o_sdata(sdata), .o_latch(latch),
    .i_sdo(sdo)
  );
  always #20 i_clk = ~i_clk;
  // ticks every other cycle; activity pulses on enabled inputs
  always @(posedge i_clk) begin
    #1;
    t1 = tk_en & ~t1;
    act = act_en & {3{t1}};
  end
  // hang guard, well above the few thousand cycles needed
  always @(posedge i_clk) begin
    cyc_n++;
    if (cyc_n == 8000) begin
      err_count++;
      results();
    end
  end
  // compares each result with the oldest note
  always @(res_ev) begin
    samples_checked++;
    if (res !== exp_q[0]) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp_q[0], res);
    end
    void'(exp_q.pop_front());
  end
  //////////////////////////////
  task automatic results;
    $display("checked %0d, errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [31:0] xs;
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // hand one result over; #0 lets the comparer run first
  task automatic see(input string n, input logic [31:0] s);
    nm = n;
    res = s;
    -> res_ev;
    #0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    exp_q.push_back(e);
    see(n, s);
  endtask
  task automatic rchk(input string n, input logic [4:0] a,
      input logic lk, input logic [31:0] e);
    exp_q.push_back(e);
    host.rd(a, lk, q);
    see(n, q);
  endtask
  //////////////////////////////
  initial begin
    repeat (8) @(posedge i_clk);
    #1;
    rst_b = 1'b1;
    cyc(3);
    // defaults on the control outputs
    r = {4'h0, cfg.loop_one_reference_divider, cfg.loop_one_feedback_divider};
    chk("l1 div", {4'h0, 14'd96, 14'd192}, r);
    r = {2'h0, cfg.loop_two_reference_divider, cfg.loop_two_feedback_divider};
    chk("l2 div", {2'h0, 12'd4, 18'd48}, r);
    r = {25'h0, cfg.loop_two_prescaler, cfg.fast_comparison_enable,
      cfg.reference_doubler_enable, cfg.loop_one_lock_window};
    chk("misc", {25'h0, 3'd2, 4'hb}, r);
    // short counts of 8 so boundaries show quickly
    host.wr(A_DAC_CLK, 32'h01000200);
    host.wr(A_L2_PUMP, 32'h0c000200);
    host.wr(A_MANUAL_DAC_VALUE, 32'h80000200);
    w1 = 1'b1;
    w2 = 1'b1;
    tk_en = 1'b1;
    cyc(10);
    chk("early locks", 32'h0, {30'h0, l1, l2});
    cyc(30);
    chk("locks", 32'h3, {30'h0, l1, l2});
    w1 = 1'b0;
    cyc(6);
    chk("holdover in", 32'h1, {30'h0, l1, ho});
    w1 = 1'b1;
    cyc(10);
    chk("holdover held", 32'h1, {31'h0, ho});
    cyc(30);
    chk("holdover out", 32'h2, {30'h0, l1, ho});
    // manual value, then back to tracking
    host.wr(A_MANUAL_DAC_VALUE, 32'h55500200);
    cyc(20);
    chk("manual dac", 32'h155, {22'h0, dac});
    r = xs();
    tune = {2'h1, r[7:0]};
    host.wr(A_MANUAL_DAC_VALUE, 32'h55400200);
    cyc(20);
    chk("tracking dac", {22'h0, tune}, {22'h0, dac});
    rchk("dac read", A_MANUAL_DAC_VALUE, 1'b0, {tune, 22'h200});
    // tune at ground rail trips loop one
    tune = 10'h000;
    host.wr(A_BUF_TRIP, 32'h12000020);
    cyc(20);
    chk("rail trip", 32'h2, {30'h0, rail, l1});
    for (int c = 0; c < 4; c++) begin
      host.wr(A_L1_PUMP, {6'h0, {3{c[1:0]}}, 14'd96, c[0], 5'h0});
      r = {19'h0, cfg.loop_one_pump_tristate, cfg.predivide_ratio};
      chk("prediv", {19'h0, c[0], {3{4'h1 << c}}}, r);
    end
    // random dividers kept nonzero; lock set by the read
    r = xs() | 32'h00100040;
    host.wr(A_DIV_RN, r);
    chk("l2 ref", {20'h0, r[31:20]},
      {20'h0, cfg.loop_two_reference_divider});
    rchk("div reg", A_DIV_RN, 1'b1, r & 32'hffffffc0);
    host.wr(A_DIV_RN, ~r);
    rchk("locked reg", A_DIV_RN, 1'b0, r & 32'hffffffc0);
    host.lv = 1'b1;
    rchk("level high", A_DIV_RN, 1'b0, r & 32'hffffffc0);
    host.lv = 1'b0;
    rchk("select", A_READBACK, 1'b0, 32'h001f0000);
    host.wr(5'h05, 32'hffffffe0);
    rchk("unmapped", 5'h05, 1'b0, 32'h0);
    host.wr(A_XTAL, 32'hffffffe0);
    rchk("reserved", A_XTAL, 1'b0, 32'hc0000000);
    // calibration copy written equal to the divider, as the host must
    r = (xs() & 32'h007fffe0) | 32'h00000020;
    host.wr(A_L2_FB, r | 32'h02000000);
    host.wr(A_CAL, r | 32'h07800000);
    q = {14'h0, cfg.loop_two_feedback_calibration_copy};
    r = {14'h0, r[22:5]};
    chk("l2 n", r, {14'h0, cfg.loop_two_feedback_divider});
    chk("n copy", r, q);
    // reference two idle, then all idle
    act_en = 3'h3;
    cyc(40);
    chk("loss", 32'h4, {29'h0, input_signal_loss});
    act_en = 3'h0;
    cyc(40);
    chk("loss all", 32'h7, {29'h0, input_signal_loss});
    results();
  end
endmodule // pll_holdover_config_bank_bench
